// ### rvsd_bank.sv
// regulator voltage and strobe delay register bank with sequencer
//
// Operation
// R1: a write to the regulator voltage register is taken only while the unlock input is high.
// R2: every taken write to the regulator voltage register blanks over/under-voltage monitoring for 5 ms.
// R3: the six-bit code in bits 5..0 selects 0.900 V up in 25 mV steps to 1.550 V, then 50 mV steps to 3.400 V.
// R4: the regulator voltage register sits at 0x1B and resets to 0x1F, which is 1.800 V.
// R5: bits 7 and 6 of the regulator voltage register are read-only and read as zero.
// R6: the wait between strobe n and n+1 is 2 ms when its select bit is clear and 5 ms when set.
// R7: bit 0 selects the gap after strobe 1, through bit 7 for the gap after strobe 8.
// R8: the sequencer delay register sits at 0x20 and resets to 0x00, all gaps short.
// R9: with the multiplier set, gaps are ten times longer during power-down only.
// R10: the sequencer delay register also ignores writes while the unlock input is low.
`timescale 1ns/1ps
module rvsd_bank
    import rvsd_pkg::*;
#(
    parameter int unsigned SHORT_CYC = GAP_SHORT_CYC,
    parameter int unsigned LONG_CYC = GAP_LONG_CYC,
    parameter int unsigned BLANK_LEN_CYC = BLANK_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_en_i,
    input wire logic unlock_i,
    input wire logic power_down_delay_multiplier_i,
    input wire logic power_up_req_i,
    input wire logic power_down_req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic wr_refused_o,
    output logic [VOLT_W-1:0] linear_regulator_voltage_o,
    output logic [GAP_BITS-1:0] sequencer_delay_select_o,
    output logic monitor_blank_o,
    output logic strobe_o,
    output logic [3:0] strobe_num_o,
    output logic seq_busy_o
);
    typedef struct packed {
        logic [7:0] ldo_volt;
        logic [7:0] seq_dly;
        logic [7:0] rdata;
        logic rvalid;
        logic refused;
        logic blank;
        logic [CNT_W-1:0] blank_cnt;
    } rvsd_bank_s;

    rvsd_bank_s s_q;
    rvsd_bank_s s_d;

    rvsd_seq_if sif ();

    function automatic logic [7:0] read_mux(input logic [7:0] a, input rvsd_bank_s s);
        unique case (a)
            LDO_VOLT_ADDR: read_mux = s.ldo_volt & LDO_VOLT_MASK; // R5
            SEQ_DLY_ADDR: read_mux = s.seq_dly;
            default: read_mux = UNMAPPED_DATA;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.refused = 1'b0;
        if (s_q.blank) begin
            if (s_q.blank_cnt == '0) begin
                s_d.blank = 1'b0;
            end else begin
                s_d.blank_cnt = CNT_W'(s_q.blank_cnt - 1'b1);
            end
        end
        if (rd_en_i) begin
            s_d.rdata = read_mux(addr_i, s_q);
            s_d.rvalid = 1'b1;
        end
        if (wr_en_i) begin
            if (addr_i == LDO_VOLT_ADDR) begin // R4
                if (unlock_i) begin // R1
                    // code kept as written; the analog side decodes the voltage steps
                    s_d.ldo_volt = wdata_i & LDO_VOLT_MASK; // R3 R5
                    // a rewrite during blanking restarts the full interval
                    s_d.blank = 1'b1; // R2
                    s_d.blank_cnt = CNT_W'(BLANK_LEN_CYC - 1); // R2
                end else begin
                    s_d.refused = 1'b1;
                end
            end else if (addr_i == SEQ_DLY_ADDR) begin // R8
                if (unlock_i) begin // R10
                    s_d.seq_dly = wdata_i;
                end else begin
                    s_d.refused = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{ldo_volt: LDO_VOLT_RESET, seq_dly: SEQ_DLY_RESET, rdata: 8'h00, rvalid: 1'b0, // R4 R8
                     refused: 1'b0, blank: 1'b0, blank_cnt: '0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign sif.start_up = power_up_req_i;
    assign sif.start_down = power_down_req_i;
    assign sif.down_mult = power_down_delay_multiplier_i; // R9
    assign sif.gap_sel = s_q.seq_dly; // R7

    rvsd_sequencer #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_seq (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .sif(sif.seq)
    );

    assign rdata_o = s_q.rdata;
    assign rvalid_o = s_q.rvalid;
    assign wr_refused_o = s_q.refused;
    assign linear_regulator_voltage_o = s_q.ldo_volt[VOLT_W-1:0];
    assign sequencer_delay_select_o = s_q.seq_dly;
    assign monitor_blank_o = s_q.blank;
    assign strobe_o = sif.strobe;
    assign strobe_num_o = sif.strobe_num;
    assign seq_busy_o = sif.busy;
endmodule

// ### rvsd_host.sv
// host model issuing single-byte register cycles
`timescale 1ns/1ps
module rvsd_host (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic wr_en_o,
    output logic [7:0] wdata_o,
    output logic rd_en_o
);
    initial begin
        addr_o = 8'h00;
        wr_en_o = 1'b0;
        wdata_o = 8'h00;
        rd_en_o = 1'b0;
    end
    // released bus shows the inverse so stale values cannot pass as live
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= wr;
        rd_en_o <= !wr;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
endmodule

// ### rvsd_monitor.sv
// port assertions for the voltage and strobe delay bank
`timescale 1ns/1ps
module rvsd_monitor
    import rvsd_pkg::*;
#(
    parameter int unsigned BLANK_LEN_CYC = BLANK_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_en_i,
    input wire logic unlock_i,
    input wire logic power_up_req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wr_refused_o,
    input wire logic [VOLT_W-1:0] linear_regulator_voltage_o,
    input wire logic [GAP_BITS-1:0] sequencer_delay_select_o,
    input wire logic monitor_blank_o,
    input wire logic strobe_o,
    input wire logic [3:0] strobe_num_o,
    input wire logic seq_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic wv = ce_i && wr_en_i && addr_i == LDO_VOLT_ADDR;
    wire logic ws = ce_i && wr_en_i && addr_i == SEQ_DLY_ADDR;
    a_volt_lock: assert property (wv && !unlock_i |=>
        wr_refused_o && $stable(linear_regulator_voltage_o)) else $error("volt lock");
    a_gap_lock: assert property (ws && !unlock_i |=>
        wr_refused_o && $stable(sequencer_delay_select_o)) else $error("gap lock");
    a_volt_write: assert property (wv && unlock_i |=>
        monitor_blank_o && {2'h0, linear_regulator_voltage_o} == ($past(wdata_i) & LDO_VOLT_MASK))
        else $error("volt write");
    a_gap_write: assert property (ws && unlock_i |=>
        sequencer_delay_select_o == $past(wdata_i)) else $error("gap write");
    a_blank_len: assert property ($fell(monitor_blank_o) |->
        $past(monitor_blank_o, BLANK_LEN_CYC)) else $error("blank short");
    a_rsvd_zero: assert property (rvalid_o && $past(addr_i) == LDO_VOLT_ADDR |->
        rdata_o[7:6] == 2'b00) else $error("reserved bits");
    a_read_answer: assert property (ce_i && rd_en_i |=> rvalid_o) else $error("no rvalid");
    a_up_start: assert property (ce_i && power_up_req_i && !seq_busy_o |->
        ##2 strobe_o && strobe_num_o == STROBE_FIRST) else $error("first strobe");
    a_min_gap: assert property (strobe_o && seq_busy_o |=>
        !strobe_o [*8] ##1 !strobe_o) else $error("gap short");
    c_volt: cover property (wv && unlock_i);
    c_lock: cover property (wr_refused_o);
    a_write_taken: assert property (ce_i && wr_en_i && unlock_i |=> !wr_refused_o) else $error("taken refused");
    c_done: cover property ($fell(seq_busy_o));
    c_down_end: cover property (strobe_o && strobe_num_o == STROBE_FIRST && !seq_busy_o);
endmodule

bind rvsd_bank rvsd_monitor #(.BLANK_LEN_CYC(BLANK_LEN_CYC)) rvsd_monitor_i (.clk_i, .nrst_i, .ce_i,
    .addr_i, .wr_en_i, .wdata_i, .rd_en_i, .unlock_i, .power_up_req_i, .rdata_o, .rvalid_o,
    .wr_refused_o, .linear_regulator_voltage_o, .sequencer_delay_select_o, .monitor_blank_o,
    .strobe_o, .strobe_num_o, .seq_busy_o);

// ### rvsd_pkg.sv
// constants and register map for the regulator voltage and strobe delay bank
package rvsd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned GAP_SHORT_MS = 2;
    localparam int unsigned GAP_LONG_MS = 5;
    localparam int unsigned BLANK_MS = 5;
    localparam int unsigned DOWN_FACTOR = 10;
    localparam int unsigned GAP_SHORT_CYC = GAP_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned GAP_LONG_CYC = GAP_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned BLANK_CYC = BLANK_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned EMIT_OVERHEAD_CYC = 2;

    localparam logic [7:0] LDO_VOLT_ADDR = 8'h1b;
    localparam logic [7:0] SEQ_DLY_ADDR = 8'h20;
    localparam logic [7:0] LDO_VOLT_RESET = 8'h1f;
    localparam logic [7:0] SEQ_DLY_RESET = 8'h00;
    localparam logic [7:0] LDO_VOLT_MASK = 8'h3f;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam int unsigned VOLT_W = 6;
    localparam int unsigned GAP_BITS = 8;

    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_LAST = 4'h9;
    localparam logic [3:0] UP_GAP_OFS = 4'h1;
    localparam logic [3:0] DOWN_GAP_OFS = 4'h2;
endpackage

// ### rvsd_seq_if.sv
// carrier between bank control and strobe sequencer
`timescale 1ns/1ps
interface rvsd_seq_if;
    logic start_up;
    logic start_down;
    logic down_mult;
    logic [7:0] gap_sel;
    logic strobe;
    logic [3:0] strobe_num;
    logic busy;
    modport ctrl (output start_up, output start_down, output down_mult, output gap_sel,
                  input strobe, input strobe_num, input busy);
    modport seq (input start_up, input start_down, input down_mult, input gap_sel,
                 output strobe, output strobe_num, output busy);
endinterface

// ### rvsd_sequencer.sv
// strobe sequencer: strobes 1..9 with selectable gaps
`timescale 1ns/1ps
module rvsd_sequencer
    import rvsd_pkg::*;
#(
    parameter int unsigned SHORT_CYC = GAP_SHORT_CYC,
    parameter int unsigned LONG_CYC = GAP_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    rvsd_seq_if.seq sif
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EMIT,
        ST_GAP
    } rvsd_seq_state_e;

    typedef struct packed {
        rvsd_seq_state_e state;
        logic dir_down;
        logic [3:0] num;
        logic [CNT_W-1:0] cnt;
        logic strobe;
        logic [3:0] strobe_num;
        logic busy;
    } rvsd_seq_s;

    rvsd_seq_s s_q;
    rvsd_seq_s s_d;

    // gap length in cycles; the multiplier only stretches power-down gaps
    function automatic logic [CNT_W-1:0] gap_len(input logic long_sel, input logic down, input logic mult);
        logic [CNT_W-1:0] base;
        base = long_sel ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC); // R6
        gap_len = (down && mult) ? CNT_W'(base * DOWN_FACTOR) : base; // R9
    endfunction

    always_comb begin
        logic [2:0] idx;
        idx = '0;
        s_d = s_q;
        s_d.strobe = 1'b0;
        unique case (s_q.state)
            ST_IDLE: begin
                if (sif.start_up) begin
                    s_d.dir_down = 1'b0;
                    s_d.num = STROBE_FIRST;
                    s_d.state = ST_EMIT;
                end else if (sif.start_down) begin
                    s_d.dir_down = 1'b1;
                    s_d.num = STROBE_LAST;
                    s_d.state = ST_EMIT;
                end
            end
            ST_EMIT: begin
                s_d.strobe = 1'b1;
                s_d.strobe_num = s_q.num;
                if (s_q.dir_down ? (s_q.num == STROBE_FIRST) : (s_q.num == STROBE_LAST)) begin
                    s_d.state = ST_IDLE;
                end else begin
                    // gap between strobe n and n+1 is bit n-1, either direction
                    idx = s_q.dir_down ? 3'(s_q.num - DOWN_GAP_OFS) : 3'(s_q.num - UP_GAP_OFS); // R7
                    // two cycles of emit/step overhead are folded into the load
                    s_d.cnt = gap_len(sif.gap_sel[idx], s_q.dir_down, sif.down_mult) - CNT_W'(EMIT_OVERHEAD_CYC); // R6
                    s_d.state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (s_q.cnt == '0) begin
                    s_d.num = s_q.dir_down ? 4'(s_q.num - 4'h1) : 4'(s_q.num + 4'h1);
                    s_d.state = ST_EMIT;
                end else begin
                    s_d.cnt = CNT_W'(s_q.cnt - 1'b1);
                end
            end
        endcase
        s_d.busy = (s_d.state != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{state: ST_IDLE, dir_down: 1'b0, num: 4'h0, cnt: '0, strobe: 1'b0,
                     strobe_num: 4'h0, busy: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign sif.strobe = s_q.strobe;
    assign sif.strobe_num = s_q.strobe_num;
    assign sif.busy = s_q.busy;
endmodule

// ### testbench.sv
// self-checking bench for the voltage and strobe delay bank
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic unlock_i = 1'b0;
    logic mult = 1'b0;
    logic ce = 1'b1;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic [7:0] addr_i, wdata_i, rdata_o, sel;
    logic wr_en_i, rd_en_i, rvalid_o, refused, blank, strobe, busy;
    logic [5:0] volt;
    logic [3:0] num;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk_i = ~clk_i;
    rvsd_host rvsd_host_i (.clk_i, .addr_o(addr_i), .wr_en_o(wr_en_i), .wdata_o(wdata_i), .rd_en_o(rd_en_i));
    rvsd_bank #(.SHORT_CYC(10), .LONG_CYC(25), .BLANK_LEN_CYC(25)) rvsd_bank_i (.clk_i, .nrst_i,
        .ce_i(ce), .addr_i, .wr_en_i, .wdata_i, .rd_en_i, .unlock_i, .power_down_delay_multiplier_i(mult),
        .power_up_req_i(up), .power_down_req_i(dn), .rdata_o, .rvalid_o, .wr_refused_o(refused),
        .linear_regulator_voltage_o(volt), .sequencer_delay_select_o(sel), .monitor_blank_o(blank),
        .strobe_o(strobe), .strobe_num_o(num), .seq_busy_o(busy));
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // generous ceiling: the longest run is one slowed power-down
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        rvsd_host_i.xfer(w, a, d);
        #1;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk("rvalid", 1, rvalid_o);
        chk("rdata", e, rdata_o);
    endtask
    task automatic t_lock;
        acc(1'b1, 8'h1b, 8'h05);
        chk("refused", 1, refused);
        chk("blank", 0, blank);
        rd_chk(8'h1b, 8'h1f);
        acc(1'b1, 8'h20, 8'hff);
        chk("refused", 1, refused);
        rd_chk(8'h20, 8'h00);
    endtask
    task automatic t_volt;
        int n;
        n = 0;
        @(posedge clk_i);
        unlock_i <= 1'b1;
        acc(1'b1, 8'h1b, 8'hff);
        chk("volt", 8'h3f, volt);
        chk("refused", 0, refused);
        while (blank === 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("blank len", 25, n);
        rd_chk(8'h1b, 8'h3f);
    endtask
    task automatic t_seq(logic [7:0] w, logic down, logic m);
        int t0;
        int g;
        int b;
        acc(1'b1, 8'h20, w);
        chk("gap sel", w, sel);
        @(posedge clk_i);
        mult <= m;
        up <= !down;
        dn <= down;
        @(posedge clk_i);
        up <= 1'b0;
        dn <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            g = 0;
            do begin
                @(posedge clk_i);
                #1;
                g++;
            end while (strobe !== 1'b1 && g < 3000);
            b = down ? 8 - k : k - 1;
            if (k > 0) chk("gap", (w[b] ? 25 : 10) * ((down && m) ? 10 : 1), cyc - t0);
            chk("num", down ? 9 - k : k + 1, num);
            t0 = cyc;
        end
        chk("busy", 0, busy);
    endtask
    // enable low for ten edges: no write taken, blank countdown held
    task automatic t_ce;
        int n;
        n = 0;
        acc(1'b1, 8'h1b, 8'h2a);
        chk("volt", 8'h2a, volt);
        @(posedge clk_i);
        ce <= 1'b0;
        acc(1'b1, 8'h20, 8'h55);
        chk("frozen sel", 8'h00, sel);
        repeat (8) @(posedge clk_i);
        ce <= 1'b1;
        while (blank === 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // one counting edge passed before the freeze
        chk("frozen blank", 25 - 1, n);
    endtask
    task automatic t_rst;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        chk("rst volt", 8'h1f, volt);
        chk("rst sel", 8'h00, sel);
        chk("rst busy", 0, busy);
        rd_chk(8'h1b, 8'h1f);
        rd_chk(8'h20, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(8'h1b, 8'h1f);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h1c, 8'h00);
        t_lock();
        t_volt();
        t_ce();
        t_seq(8'h81, 1'b0, 1'b1);
        t_seq(8'h41, 1'b1, 1'b1);
        t_seq(8'h82, 1'b1, 1'b0);
        t_rst();
        end_sim();
    end
endmodule
